/* design/fault_sup_pkg.sv */
// package for the switch fault supervisor: carriers, state codes, timing
// assumes a single 50 MHz core clock and synchronous active-high reset
package fault_sup_pkg;
  localparam int NUM_CH = 2;
  // core clock period in ns
  localparam int CLK_PERIOD_NS = 20;
  // fast fault turn-off bound in ns and its cycle count (rounded down)
  localparam int FAST_OFF_NS = 40;
  localparam int FAST_OFF_CYC = (FAST_OFF_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (FAST_OFF_NS / CLK_PERIOD_NS);
  // status word bit positions
  localparam int ST_SUPPLY_HIGH = 0;
  localparam int ST_SUPPLY_LOW = 1;
  localparam int ST_SHORT0 = 2;
  localparam int ST_SHORT1 = 3;
  localparam int ST_OVERCUR0 = 4;
  localparam int ST_OVERCUR1 = 5;
  localparam int ST_OVERTEMP0 = 6;
  localparam int ST_OVERTEMP1 = 7;
  localparam int STATUS_W = 8;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 8'h00;

  typedef enum logic [2:0] {
    MODE_SERIAL = 3'b001,
    MODE_FAILSAFE = 3'b010,
    MODE_BLIND = 3'b100
  } mode_t;

  // analog comparator results, one bit each
  typedef struct packed {
    logic supplyHigh;
    logic supplyHighRelease;
    logic supplyLow;
    logic supplyBelowMin;
    logic logicRailFail;
    logic porLow;
    logic systemGndLoss;
    logic loadGndLoss;
    logic deviceGndHigh;
  } sense_t;

  // per-channel comparator results
  typedef struct packed {
    logic hardShort;
    logic overCurrent;
    logic overTemp;
  } chan_sense_t;

  // configuration from the serial side
  typedef struct packed {
    logic supplyHighGuardOff;
    logic logicRailLossEnable;
    logic retryEnable;
  } setup_t;
endpackage : fault_sup_pkg

/* design/fault_channel.sv */
// one output channel: latched faults, delatch, retry request, fast off
// assumes fault comparators are synchronous to core_clk
module fault_channel (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clearAll,
  input fault_sup_pkg::chan_sense_t sense,
  input wire logic senseValid,
  input wire logic driveRequest,
  input wire logic delatch,
  input wire logic supplyOff,
  input wire logic supplyLowActive,
  input wire logic retryEnable,
  input wire logic retryTick,
  input wire logic readClear,
  output logic channelOn,
  output logic fastOff,
  output logic shortFlag,
  output logic overCurFlag,
  output logic overTempFlag,
  output logic latched,
  output logic retryCond
);
  typedef struct packed {
    logic shortQ;
    logic ocQ;
    logic otQ;
    logic latchQ;
    logic wasOnQ;
    logic onQ;
    logic otPendQ;
  } ch_state_t;

  ch_state_t state_q, state_d;
  logic turnOn;
  logic causeGone;

  always_comb begin
    state_d = state_q;
    turnOn = driveRequest && !state_q.wasOnQ;
    causeGone = !sense.hardShort && !sense.overCurrent && !sense.overTemp;
    // delatch, or an enabled retry tick with a retry condition and no undervoltage, releases the latch
    if (delatch || (retryEnable && retryTick && retryCond &&
        !supplyLowActive)) begin
      state_d.latchQ = 1'b0;
    end
    // severe short counts at turn-on or while the channel is on
    if (sense.hardShort && (turnOn || state_q.onQ)) begin
      state_d.shortQ = 1'b1;
      state_d.latchQ = 1'b1;
    end
    if (sense.overCurrent && state_q.onQ) begin
      state_d.ocQ = 1'b1;
      state_d.latchQ = 1'b1;
    end
    // overtemperature acts always, reported only when valid
    if (sense.overTemp) begin
      state_d.latchQ = 1'b1;
      state_d.otPendQ = 1'b1;
    end
    if (state_q.otPendQ && senseValid) begin
      state_d.otQ = 1'b1;
      state_d.otPendQ = sense.overTemp;
    end
    // read clears only after cause gone and delatched; set wins
    if (readClear && causeGone && !state_q.latchQ) begin
      state_d.shortQ = sense.hardShort;
      state_d.ocQ = sense.overCurrent;
      state_d.otQ = sense.overTemp && senseValid;
    end
    state_d.wasOnQ = driveRequest;
    state_d.onQ = driveRequest && !state_d.latchQ && !supplyOff;
    if (clearAll) begin
      state_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // fast off bypasses slew control
  assign fastOff = state_q.onQ && (sense.hardShort || sense.overCurrent ||
    sense.overTemp || supplyLowActive);
  assign channelOn = state_q.onQ && !fastOff;
  assign shortFlag = state_q.shortQ;
  assign overCurFlag = state_q.ocQ;
  assign overTempFlag = state_q.otQ;
  assign latched = state_q.latchQ;
  // retry on short, overcurrent, overtemperature or undervoltage
  assign retryCond = state_q.shortQ || state_q.ocQ || state_q.otQ ||
    state_q.otPendQ || supplyLowActive;
endmodule : fault_channel

/* design/switch_fault_supervisor.sv */
// fault supervisor of a dual high-side switch: supply, ground and
// logic-rail handling, fault line, status word with read-to-clear
// assumes comparator inputs and host strobes are synchronous to core_clk
module switch_fault_supervisor #(
  parameter int CHANNELS = fault_sup_pkg::NUM_CH
) (
  input wire logic core_clk,
  input wire logic reset,
  input fault_sup_pkg::sense_t supplySense,
  input fault_sup_pkg::chan_sense_t chanSense0,
  input fault_sup_pkg::chan_sense_t chanSense1,
  input wire logic setupWrite,
  input fault_sup_pkg::setup_t setupData,
  input wire logic [1:0] channelDriveRequest,
  input wire logic [1:0] directDriveWire,
  input wire logic [1:0] delatchRequest,
  input wire logic retryTick,
  input wire logic statusRead,
  output logic [fault_sup_pkg::STATUS_W-1:0] statusWord,
  output logic statusValid,
  output logic serialActive,
  output logic failSafe,
  output logic [1:0] channelOn,
  output logic [1:0] fastOff,
  output logic [1:0] openLoadFlag,
  output fault_sup_pkg::setup_t setupWord,
  output logic fault_line_n
);
  initial begin
    if (CHANNELS != 2) begin
      $error("switch_fault_supervisor serves exactly two channels");
    end
  end

  typedef struct packed {
    fault_sup_pkg::mode_t mode;
    fault_sup_pkg::setup_t setup;
    logic supplyHighQ;
    logic supplyHighHoldQ;
    logic supplyLowQ;
    logic supplyLowActiveQ;
    logic [1:0] openLoadQ;
    logic [fault_sup_pkg::STATUS_W-1:0] statusQ;
    logic railLostQ;
  } top_state_t;

  top_state_t state_q, state_d;

  logic clearAll;
  logic failSafeNow;
  logic supplyOff;
  logic senseValid;
  logic [1:0] effRequest;
  logic [1:0] chOn;
  logic [1:0] chFast;
  logic [1:0] chShort;
  logic [1:0] chOc;
  logic [1:0] chOt;
  logic [1:0] chLatched;
  logic [1:0] chRetry;
  logic readClear;
  logic anyOn;
  logic protectFault;

  // rail failure with logicRailLossEnable set, in its first cycle, or total por clears channels, setup, flags and status word, not the overvoltage hold
  assign clearAll = (supplySense.logicRailFail &&
    state_q.setup.logicRailLossEnable && !state_q.railLostQ) ||
    supplySense.porLow;
  assign failSafeNow = state_q.mode == fault_sup_pkg::MODE_FAILSAFE;
  // status reads are honoured only while the serial side works
  assign readClear = statusRead &&
    state_q.mode == fault_sup_pkg::MODE_SERIAL &&
    !supplySense.logicRailFail;
  // channels off on overvoltage hold, undervoltage, system ground loss
  assign supplyOff = ((state_q.supplyHighHoldQ || supplySense.supplyHigh) &&
    !state_q.setup.supplyHighGuardOff) ||
    supplySense.supplyLow ||
    supplySense.systemGndLoss;
  assign senseValid = !supplySense.supplyLow;
  // fail-safe: channels follow direct drive wires
  assign effRequest = failSafeNow ? directDriveWire : channelDriveRequest;

  fault_channel u_ch0 (
    .core_clk(core_clk),
    .reset(reset),
    .clearAll(clearAll),
    .sense(chanSense0),
    .senseValid(senseValid),
    .driveRequest(effRequest[0]),
    .delatch(delatchRequest[0]),
    .supplyOff(supplyOff),
    .supplyLowActive(supplySense.supplyLow),
    .retryEnable(state_q.setup.retryEnable),
    .retryTick(retryTick),
    .readClear(readClear),
    .channelOn(chOn[0]),
    .fastOff(chFast[0]),
    .shortFlag(chShort[0]),
    .overCurFlag(chOc[0]),
    .overTempFlag(chOt[0]),
    .latched(chLatched[0]),
    .retryCond(chRetry[0])
  );

  fault_channel u_ch1 (
    .core_clk(core_clk),
    .reset(reset),
    .clearAll(clearAll),
    .sense(chanSense1),
    .senseValid(senseValid),
    .driveRequest(effRequest[1]),
    .delatch(delatchRequest[1]),
    .supplyOff(supplyOff),
    .supplyLowActive(supplySense.supplyLow),
    .retryEnable(state_q.setup.retryEnable),
    .retryTick(retryTick),
    .readClear(readClear),
    .channelOn(chOn[1]),
    .fastOff(chFast[1]),
    .shortFlag(chShort[1]),
    .overCurFlag(chOc[1]),
    .overTempFlag(chOt[1]),
    .latched(chLatched[1]),
    .retryCond(chRetry[1])
  );

  assign anyOn = |chOn;

  always_comb begin
    state_d = state_q;
    // setup accepted only under serial control
    if (setupWrite && state_q.mode == fault_sup_pkg::MODE_SERIAL) begin
      state_d.setup = setupData;
    end
    // overvoltage: flag always, hold until below hysteresis
    if (supplySense.supplyHigh) begin
      state_d.supplyHighQ = 1'b1;
      state_d.supplyHighHoldQ = 1'b1;
    end else if (supplySense.supplyHighRelease) begin
      state_d.supplyHighHoldQ = 1'b0;
    end
    // flag clears on read once the condition is over
    if (readClear && !supplySense.supplyHigh &&
        !state_q.supplyHighHoldQ) begin
      state_d.supplyHighQ = 1'b0;
    end
    // undervoltage shared flag
    state_d.supplyLowActiveQ = supplySense.supplyLow;
    if (supplySense.supplyLow) begin
      state_d.supplyLowQ = 1'b1;
    end else if (state_q.supplyLowQ) begin
      // warning until an output is on then read clears it
      if (readClear && anyOn) begin
        state_d.supplyLowQ = 1'b0;
      end
    end
    // load ground loss flags open load without changing the state
    state_d.openLoadQ = state_q.openLoadQ |
      (supplySense.loadGndLoss ? chOn : 2'b00);
    if (readClear && !supplySense.loadGndLoss) begin
      state_d.openLoadQ = 2'b00;
    end
    state_d.railLostQ = supplySense.logicRailFail;
    case (state_q.mode)
      fault_sup_pkg::MODE_SERIAL: begin
        if (supplySense.deviceGndHigh) begin
          state_d.mode = fault_sup_pkg::MODE_FAILSAFE;
        end else if (supplySense.logicRailFail) begin
          state_d.mode = state_q.setup.logicRailLossEnable ?
            fault_sup_pkg::MODE_FAILSAFE :
            fault_sup_pkg::MODE_BLIND;
        end
      end
      fault_sup_pkg::MODE_BLIND: begin
        if (!supplySense.logicRailFail) begin
          state_d.mode = fault_sup_pkg::MODE_SERIAL;
        end
      end
      fault_sup_pkg::MODE_FAILSAFE: begin
        state_d.mode = fault_sup_pkg::MODE_FAILSAFE;
      end
      default: begin
        state_d.mode = fault_sup_pkg::MODE_SERIAL;
      end
    endcase
    // status word; rebuilt from the current flags every cycle
    state_d.statusQ = fault_sup_pkg::STATUS_RESET;
    state_d.statusQ[fault_sup_pkg::ST_SUPPLY_HIGH] = state_d.supplyHighQ;
    state_d.statusQ[fault_sup_pkg::ST_SUPPLY_LOW] = state_d.supplyLowQ;
    state_d.statusQ[fault_sup_pkg::ST_SHORT0] = chShort[0];
    state_d.statusQ[fault_sup_pkg::ST_SHORT1] = chShort[1];
    state_d.statusQ[fault_sup_pkg::ST_OVERCUR0] = chOc[0];
    state_d.statusQ[fault_sup_pkg::ST_OVERCUR1] = chOc[1];
    state_d.statusQ[fault_sup_pkg::ST_OVERTEMP0] = chOt[0];
    state_d.statusQ[fault_sup_pkg::ST_OVERTEMP1] = chOt[1];
    if (clearAll) begin
      state_d.setup = '0;
      state_d.supplyHighQ = 1'b0;
      state_d.supplyLowQ = 1'b0;
      state_d.openLoadQ = 2'b00;
      state_d.statusQ = fault_sup_pkg::STATUS_RESET;
      if (supplySense.porLow) begin
        state_d.mode = fault_sup_pkg::MODE_SERIAL;
      end else begin
        state_d.mode = fault_sup_pkg::MODE_FAILSAFE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= '0;
      state_q.mode <= fault_sup_pkg::MODE_SERIAL;
    end else begin
      state_q <= state_d;
    end
  end

  // fault line: latched or fast-off channel faults, overvoltage hold unless
  // supplyHighGuardOff, and undervoltage, even without the logic rail
  assign protectFault = (|chLatched) || (|chFast) ||
    (state_q.supplyHighHoldQ && !state_q.setup.supplyHighGuardOff) ||
    supplySense.supplyLow;
  assign fault_line_n = !protectFault;

  assign channelOn = chOn;
  assign fastOff = chFast;
  assign openLoadFlag = state_q.openLoadQ;
  assign setupWord = state_q.setup;
  // channel flags are already registered in the channels; taking them
  // directly keeps every flag but overtemperature (two cycles) one cycle behind its cause
  always_comb begin
    statusWord = state_q.statusQ;
    statusWord[fault_sup_pkg::ST_SHORT0] = chShort[0];
    statusWord[fault_sup_pkg::ST_SHORT1] = chShort[1];
    statusWord[fault_sup_pkg::ST_OVERCUR0] = chOc[0];
    statusWord[fault_sup_pkg::ST_OVERCUR1] = chOc[1];
    statusWord[fault_sup_pkg::ST_OVERTEMP0] = chOt[0];
    statusWord[fault_sup_pkg::ST_OVERTEMP1] = chOt[1];
  end
  assign statusValid = state_q.mode == fault_sup_pkg::MODE_SERIAL;
  assign serialActive = state_q.mode != fault_sup_pkg::MODE_FAILSAFE;
  assign failSafe = failSafeNow;
endmodule : switch_fault_supervisor

/* verification/switch_fault_supervisor_chk.sv */
// port assertions for the switch fault supervisor
// assumes one core_clk domain with synchronous active-high reset
module switch_fault_supervisor_chk #(
  parameter int CHANNELS = fault_sup_pkg::NUM_CH
) (
  input wire logic core_clk,
  input wire logic reset,
  input fault_sup_pkg::sense_t supplySense,
  input fault_sup_pkg::chan_sense_t chanSense0,
  input fault_sup_pkg::chan_sense_t chanSense1,
  input wire logic statusRead,
  input logic [fault_sup_pkg::STATUS_W-1:0] statusWord,
  input logic statusValid,
  input logic serialActive,
  input logic failSafe,
  input logic [1:0] channelOn,
  input logic [1:0] fastOff,
  input fault_sup_pkg::setup_t setupWord,
  input logic fault_line_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  logic live;
  // flags are only tracked in serial mode without a clearing event
  assign live = statusValid && !supplySense.porLow &&
    !supplySense.logicRailFail;
  short_off_a: assert property (
    chanSense0.hardShort |-> !channelOn[0] && !fault_line_n)
    else $error("channel on or fault line high during short");
  short_flag_a: assert property (
    chanSense0.hardShort && fastOff[0] && live |=> statusWord[2])
    else $error("short flag not set");
  ov_off_a: assert property (
    supplySense.supplyHigh && !setupWord.supplyHighGuardOff
    |=> channelOn == 2'h0 && !fault_line_n)
    else $error("overvoltage did not turn off");
  ov_flag_a: assert property (
    supplySense.supplyHigh && live |=> statusWord[0])
    else $error("overvoltage flag not set");
  ov_clear_a: assert property (
    $fell(statusWord[0]) && !$past(reset) && !$past(supplySense.porLow)
    && !$past(supplySense.logicRailFail) |-> $past(statusRead))
    else $error("overvoltage flag cleared without read");
  uv_off_a: assert property (
    supplySense.supplyLow |-> channelOn == 2'h0 && !fault_line_n)
    else $error("undervoltage did not turn off");
  fast_off_a: assert property (
    fastOff != 2'h0 |-> (fastOff & channelOn) == 2'h0)
    else $error("channel on during fast off");
  gnd_off_a: assert property (
    supplySense.systemGndLoss |=> channelOn == 2'h0)
    else $error("channel on after ground loss");
  gnd_high_a: assert property (
    supplySense.deviceGndHigh && !supplySense.porLow
    |=> failSafe && !serialActive && !statusValid)
    else $error("no fail-safe on ground high");
endmodule : switch_fault_supervisor_chk

bind switch_fault_supervisor switch_fault_supervisor_chk #(
  .CHANNELS(CHANNELS)
) switch_fault_supervisor_chk_i (
  .core_clk(core_clk), .reset(reset), .supplySense(supplySense),
  .chanSense0(chanSense0), .chanSense1(chanSense1),
  .statusRead(statusRead), .statusWord(statusWord),
  .statusValid(statusValid), .serialActive(serialActive),
  .failSafe(failSafe), .channelOn(channelOn), .fastOff(fastOff),
  .setupWord(setupWord), .fault_line_n(fault_line_n)
);

/* verification/host_model.sv */
// host side: issues one-cycle status reads and keeps the word read
// assumes statusWord is registered on core_clk
module host_model (
  input wire logic core_clk,
  input wire logic readReq,
  input wire logic [fault_sup_pkg::STATUS_W-1:0] statusWord,
  output logic statusRead = 1'h0,
  output logic [fault_sup_pkg::STATUS_W-1:0] readData = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req;
  // strobe moves just after the edge; data taken at the edge that sees it
  always @(posedge core_clk) begin
    req = readReq;
    if (statusRead) begin
      readData = statusWord;
    end
    #2 statusRead = req;
  end
endmodule : host_model

/* verification/tb.sv */
// self-checking bench for the switch fault supervisor
// assumes host_model performs the status reads
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  fault_sup_pkg::sense_t sense;
  fault_sup_pkg::chan_sense_t cs0, cs1;
  fault_sup_pkg::setup_t setupData, setupWord;
  logic setupWrite, readReq, statusRead, statusValid, serialActive;
  logic failSafe, faultN, retryTick;
  logic [1:0] driveReq, directWire, delatch, channelOn, fastOff, openLoad;
  logic [7:0] statusWord, readData;
  int fails = 0;
  int compares = 0;

  switch_fault_supervisor switch_fault_supervisor_i (
    .core_clk(core_clk), .reset(reset), .supplySense(sense),
    .chanSense0(cs0), .chanSense1(cs1), .setupWrite(setupWrite),
    .setupData(setupData), .channelDriveRequest(driveReq),
    .directDriveWire(directWire), .delatchRequest(delatch),
    .retryTick(retryTick), .statusRead(statusRead), .statusWord(statusWord),
    .statusValid(statusValid), .serialActive(serialActive),
    .failSafe(failSafe), .channelOn(channelOn), .fastOff(fastOff),
    .openLoadFlag(openLoad), .setupWord(setupWord), .fault_line_n(faultN)
  );
  host_model host_model_i (
    .core_clk(core_clk), .readReq(readReq), .statusWord(statusWord),
    .statusRead(statusRead), .readData(readData)
  );

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : step

  task automatic chk(input logic [7:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask : chk

  task automatic do_reset();
    reset = 1'h1;
    step(16);
    reset = 1'h0;
    step(1);
  endtask : do_reset

  task automatic read_status();
    readReq = 1'h1;
    step(1);
    readReq = 1'h0;
    step(2);
  endtask : read_status

  task automatic write_setup();
    setupWrite = 1'h1;
    step(1);
    setupWrite = 1'h0;
    step(1);
  endtask : write_setup

  task automatic pulse_delatch();
    delatch = 2'h1;
    step(1);
    delatch = 2'h0;
    step(1);
  endtask : pulse_delatch

  task automatic test_short();
    driveReq = 2'h1;
    step(2);
    cs0.hardShort = 1'h1;
    #1;
    chk({fastOff[0], channelOn[0], faultN}, 3'h4, "short");
    step(1);
    chk(statusWord[2], 1'h1, "short flag");
    cs0.hardShort = 1'h0;
    step(1);
    read_status();
    chk({channelOn[0], statusWord[2]}, 2'h1, "latched");
    pulse_delatch();
    chk({channelOn[0], faultN}, 2'h3, "delatched");
    read_status();
    chk({readData[2], statusWord[2]}, 2'h2, "read clear");
  endtask : test_short

  task automatic test_ov();
    driveReq = 2'h3;
    step(2);
    sense.supplyHigh = 1'h1;
    sense.supplyHighRelease = 1'h0;
    step(1);
    chk({channelOn, faultN}, 3'h0, "ov off");
    chk(statusWord[0], 1'h1, "ov flag");
    sense.supplyHigh = 1'h0;
    step(2);
    read_status();
    chk({channelOn, statusWord[0]}, 3'h1, "ov hold");
    sense.supplyHighRelease = 1'h1;
    step(2);
    read_status();
    chk({channelOn, statusWord[0]}, 3'h6, "ov done");
    setupData.supplyHighGuardOff = 1'h1;
    write_setup();
    sense.supplyHigh = 1'h1;
    sense.supplyHighRelease = 1'h0;
    #1;
    chk({channelOn, faultN}, 3'h7, "guard off");
    step(1);
    chk(statusWord[0], 1'h1, "ov warning");
    sense.supplyHigh = 1'h0;
    sense.supplyHighRelease = 1'h1;
    step(1);
    read_status();
  endtask : test_ov

  task automatic test_uv();
    driveReq = 2'h0;
    step(1);
    sense.supplyLow = 1'h1;
    #1;
    chk(faultN, 1'h0, "uv low");
    step(1);
    chk(statusWord[1], 1'h1, "uv flag");
    sense.supplyLow = 1'h0;
    step(1);
    read_status();
    chk({faultN, statusWord[1]}, 2'h3, "uv warning");
    pulse_delatch();
    driveReq = 2'h1;
    step(2);
    read_status();
    chk({channelOn[0], statusWord[1]}, 2'h2, "uv clear");
    sense.systemGndLoss = 1'h1;
    step(1);
    chk(channelOn, 2'h0, "gnd loss");
    sense.systemGndLoss = 1'h0;
    sense.loadGndLoss = 1'h1;
    step(2);
    chk({channelOn[0], openLoad[0]}, 2'h3, "load gnd");
    sense.loadGndLoss = 1'h0;
    setupData.retryEnable = 1'h1;
    write_setup();
    cs0.overCurrent = 1'h1;
    step(1);
    cs0.overCurrent = 1'h0;
    step(1);
    chk({channelOn[0], statusWord[4]}, 2'h1, "oc latched");
    retryTick = 1'h1;
    step(1);
    retryTick = 1'h0;
    chk(channelOn[0], 1'h1, "retry on");
  endtask : test_uv

  task automatic test_rail();
    sense.logicRailFail = 1'h1;
    step(2);
    chk({failSafe, serialActive}, 2'h1, "rail no enable");
    sense.logicRailFail = 1'h0;
    step(1);
    setupData.logicRailLossEnable = 1'h1;
    write_setup();
    cs0.overCurrent = 1'h1;
    step(1);
    cs0.overCurrent = 1'h0;
    sense.logicRailFail = 1'h1;
    directWire = 2'h2;
    step(2);
    chk({failSafe, statusValid}, 2'h2, "fail-safe");
    chk(statusWord, 8'h00, "cleared");
    chk(channelOn, 2'h2, "direct");
    cs1.overTemp = 1'h1;
    #1;
    chk({channelOn[1], faultN}, 2'h0, "rail fault");
    cs1.overTemp = 1'h0;
    sense.logicRailFail = 1'h0;
    do_reset();
    sense.deviceGndHigh = 1'h1;
    step(2);
    chk({failSafe, serialActive}, 2'h2, "gnd high");
    sense.deviceGndHigh = 1'h0;
    do_reset();
  endtask : test_rail

  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    sense = '0;
    sense.supplyHighRelease = 1'h1;
    {cs0, cs1, setupData, setupWrite, readReq, retryTick} = '0;
    {driveReq, directWire, delatch} = '0;
    do_reset();
    test_short();
    test_ov();
    test_uv();
    test_rail();
    finish_test();
  end

  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule : tb
